/* verilog/vc0_defines.svh */
// Offsets, field positions and reset values of the channel registers
// Contract
// - Max time slots field reads as zero, read-only.
// - Read-only byte 31:24 gives table offset in 16-byte units.
// - Table offset reads 0x2 upstream, 0x0 downstream.
// - Eight-bit traffic-class map, one bit per class, resets to all ones.
// - Map bit 0 is read-only; bits 7:1 are writable.
// - Writing one to load bit copies stored table into arbitration logic.
// - Writing zero to the load bit does nothing.
// - The load bit always reads as zero.
// - The load bit acts only in the upstream port.
// - A load acts only if the selected scheme uses the table.
// - Channel identifier reads zero and ignores writes.
// - Table status sets on entry write, clears when load completes; the code sets it in the upstream port only.
// - Capability shows 0x3 upstream and 0x1 downstream.
`ifndef VC0_DEFINES_SVH
`define VC0_DEFINES_SVH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define CAP_ADDR 12'h210
`define CTL_ADDR 12'h214
`define STS_ADDR 12'h218

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CAPAB_MSB 7
`define CAPAB_LSB 0
`define MAX_TIME_SLOTS_MSB 22
`define MAX_TIME_SLOTS_LSB 16
`define TBLOFF_MSB 31
`define TBLOFF_LSB 24
`define TCMAP_MSB 7
`define TCMAP_LSB 1
`define LOAD_BIT 16
`define SEL_MSB 19
`define SEL_LSB 17
`define CHID_MSB 26
`define CHID_LSB 24
`define STATUS_BIT 0
`define LANE_MAP 0
`define LANE_LOAD 2

// -----------------------------------------------------------------
// Reset and fixed values
// -----------------------------------------------------------------
`define TCMAP_RESET 7'h7f
`define SEL_RESET 3'h0
`define SCHEME_FIXED 3'h0
`define TBLOFF_UP 8'h02
`define TBLOFF_DOWN 8'h00
`define CAPAB_UP 8'h03
`define CAPAB_DOWN 8'h01
`define WORD_ZERO 32'h0000_0000

`endif

/* verilog/vc0_pkg.sv */
// State types of the channel control registers and the load tracker
package vc0_pkg;

  typedef enum logic [0:0] {
    LOAD_IDLE,
    LOAD_BUSY
  } load_state_e;

  typedef struct packed {
    load_state_e state;
    logic status;
  } tracker_s;

  typedef struct packed {
    logic [6:0] tc_map_hi;
    logic [2:0] scheme_sel;
    logic [31:0] rdata;
    logic slverr;
  } regs_s;

endpackage

/* verilog/table_load_tracker.sv */
// Table status bit and the load handshake toward the arbitration logic
`timescale 1ns/10ps
`include "vc0_defines.svh"

module table_load_tracker #(
  parameter bit UPSTREAM = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic entry_write_in,
  input wire logic done_in,
  output logic load_req_out,
  output logic status_out
);

  vc0_pkg::tracker_s st_r;
  vc0_pkg::tracker_s st_nxt;

  // Next state; a new entry write beats a completing load, so a
  // table edited in the cycle the load completes stays marked incoherent
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      vc0_pkg::LOAD_IDLE: begin
        if (start_in) begin
          st_nxt.state = vc0_pkg::LOAD_BUSY;
        end
      end
      vc0_pkg::LOAD_BUSY: begin
        if (done_in) begin
          st_nxt.state = vc0_pkg::LOAD_IDLE;
          st_nxt.status = 1'b0;
        end
      end
    endcase
    if (entry_write_in && UPSTREAM) begin
      st_nxt.status = 1'b1;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '{state: vc0_pkg::LOAD_IDLE, status: 1'b0};
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign load_req_out = (st_r.state == vc0_pkg::LOAD_BUSY);
  assign status_out = st_r.status;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence entry_written;
    ce_in && entry_write_in;
  endsequence

  a_status_sets: assert property (
    entry_written |=> status_out == UPSTREAM)
    else $error("status did not set on entry write");
  a_status_holds: assert property (
    status_out && !(ce_in && done_in && load_req_out) |=> status_out)
    else $error("status cleared without a finished load");
endmodule

/* verilog/vc0_port_arb_control_regs.sv */
// APB register bank for the single channel's arbitration control
`timescale 1ns/10ps
`include "vc0_defines.svh"

module vc0_port_arb_control_regs #(
  parameter bit UPSTREAM = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic table_entry_write_in,
  input wire logic table_load_done_in,
  output logic table_load_req_out,
  output logic table_status_out,
  output logic [7:0] traffic_class_map_out,
  output logic [2:0] arb_scheme_select_out
);

  // -----------------------------------------------------------------
  // Fixed capability values for this port flavour
  // -----------------------------------------------------------------
  localparam logic [7:0] ARB_CAP = UPSTREAM ? `CAPAB_UP : `CAPAB_DOWN;
  localparam logic [7:0] TBL_OFF = UPSTREAM ? `TBLOFF_UP : `TBLOFF_DOWN;

  vc0_pkg::regs_s st_r;
  vc0_pkg::regs_s st_nxt;

  logic setup_w;
  logic access_w;
  logic wr_ctl_w;
  logic [2:0] sel_new_w;
  logic uses_table_w;
  logic load_start_w;
  logic [31:0] cap_word_w;
  logic [31:0] ctl_word_w;
  logic [31:0] sts_word_w;
  logic status_w;

  // -----------------------------------------------------------------
  // Bus phase decode
  // -----------------------------------------------------------------

  // Setup cycle samples read data so the access phase answers from
  // flip-flops; with the clock enable high, one wait-free access cycle follows every setup
  assign setup_w = psel_in && !penable_in && ce_in;
  // A frozen block answers nothing, so the master simply waits
  assign pready_out = psel_in && penable_in && ce_in;
  assign access_w = pready_out;
  assign wr_ctl_w = access_w && pwrite_in && (paddr_in == `CTL_ADDR);

  // -----------------------------------------------------------------
  // Readback words
  // -----------------------------------------------------------------

  // Capability word: scheme bits, zero slot count, table offset
  always_comb begin
    cap_word_w = `WORD_ZERO;
    cap_word_w[`CAPAB_MSB:`CAPAB_LSB] = ARB_CAP;
    cap_word_w[`MAX_TIME_SLOTS_MSB:`MAX_TIME_SLOTS_LSB] = '0;
    cap_word_w[`TBLOFF_MSB:`TBLOFF_LSB] = TBL_OFF;
  end

  // Control word; the load bit and channel identifier read as zero
  always_comb begin
    ctl_word_w = `WORD_ZERO;
    ctl_word_w[`TCMAP_MSB:`TCMAP_LSB] = st_r.tc_map_hi;
    ctl_word_w[`TCMAP_LSB-1] = 1'b1;
    ctl_word_w[`LOAD_BIT] = 1'b0;
    ctl_word_w[`SEL_MSB:`SEL_LSB] = st_r.scheme_sel;
    ctl_word_w[`CHID_MSB:`CHID_LSB] = '0;
  end

  // Status word carries only the table coherency bit
  always_comb begin
    sts_word_w = `WORD_ZERO;
    sts_word_w[`STATUS_BIT] = status_w;
  end

  // -----------------------------------------------------------------
  // Load request gating
  // -----------------------------------------------------------------

  // The scheme in force after this write decides whether a load has
  // any meaning; a select outside the capability never loads
  always_comb begin
    sel_new_w = st_r.scheme_sel;
    if (pstrb_in[`LANE_LOAD]) begin
      sel_new_w = pwdata_in[`SEL_MSB:`SEL_LSB];
    end
    uses_table_w = (sel_new_w != `SCHEME_FIXED) &&
                   ARB_CAP[sel_new_w];
  end

  // Only a one in the load bit of an upstream port starts a load
  assign load_start_w = wr_ctl_w && pstrb_in[`LANE_LOAD] &&
                        pwdata_in[`LOAD_BIT] &&
                        UPSTREAM &&
                        uses_table_w;

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------

  // Writes land in the access cycle; reads are captured at setup.
  // Writes to the capability and status words are dropped silently
  always_comb begin
    st_nxt = st_r;
    if (setup_w) begin
      st_nxt.slverr = 1'b0;
      unique case (paddr_in)
        `CAP_ADDR: st_nxt.rdata = cap_word_w;
        `CTL_ADDR: st_nxt.rdata = ctl_word_w;
        `STS_ADDR: st_nxt.rdata = sts_word_w;
        default: begin
          st_nxt.rdata = `WORD_ZERO;
          st_nxt.slverr = 1'b1;
        end
      endcase
    end
    if (wr_ctl_w && pstrb_in[`LANE_MAP]) begin
      st_nxt.tc_map_hi = pwdata_in[`TCMAP_MSB:`TCMAP_LSB];
    end
    if (wr_ctl_w && pstrb_in[`LANE_LOAD]) begin
      st_nxt.scheme_sel = pwdata_in[`SEL_MSB:`SEL_LSB];
    end
  end

  // Single state register; the clock enable freezes everything
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '{tc_map_hi: `TCMAP_RESET,
                scheme_sel: `SEL_RESET,
                rdata: `WORD_ZERO,
                slverr: 1'b0};
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Table load tracker
  // -----------------------------------------------------------------

  // Software polls the status bit to learn the load has landed
  table_load_tracker #(
    .UPSTREAM(UPSTREAM)
  ) u_tracker (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .start_in(load_start_w),
    .entry_write_in(table_entry_write_in),
    .done_in(table_load_done_in),
    .load_req_out(table_load_req_out),
    .status_out(status_w)
  );

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata_out = st_r.rdata;
  assign pslverr_out = st_r.slverr && pready_out;
  assign table_status_out = status_w;
  assign traffic_class_map_out = {st_r.tc_map_hi, 1'b1};
  assign arb_scheme_select_out = st_r.scheme_sel;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence rd_setup(logic [ADDR_W-1:0] a);
    psel_in && !penable_in && ce_in && !pwrite_in && paddr_in == a;
  endsequence

  sequence rd_done;
    psel_in && penable_in && pready_out;
  endsequence

  sequence load_write;
    wr_ctl_w && pstrb_in[`LANE_LOAD] && pwdata_in[`LOAD_BIT] &&
    uses_table_w && !table_load_req_out;
  endsequence

  a_max_time_slots_reads_zero: assert property (
    rd_setup(`CAP_ADDR) ##1 rd_done |->
    prdata_out[`MAX_TIME_SLOTS_MSB:`MAX_TIME_SLOTS_LSB] == 7'h00 &&
    !prdata_out[`MAX_TIME_SLOTS_MSB+1])
    else $error("slot count or reserved bit not zero");

  a_offset_value: assert property (
    rd_setup(`CAP_ADDR) ##1 rd_done |->
    prdata_out[`TBLOFF_MSB:`TBLOFF_LSB] ==
    (UPSTREAM ? 8'h02 : 8'h00))
    else $error("table offset wrong for port");

  a_capab_value: assert property (
    rd_setup(`CAP_ADDR) ##1 rd_done |->
    prdata_out[`CAPAB_MSB:`CAPAB_LSB] == (UPSTREAM ? 8'h03 : 8'h01))
    else $error("capability wrong for port");

  a_load_reads_zero: assert property (
    rd_setup(`CTL_ADDR) ##1 rd_done |->
    !prdata_out[`LOAD_BIT] &&
    prdata_out[`CHID_MSB:`CHID_LSB] == 3'h0)
    else $error("load bit or channel id read nonzero");

  a_map_low_fixed: assert property (
    traffic_class_map_out[0] && $stable(traffic_class_map_out) or
    $past(wr_ctl_w && pstrb_in[`LANE_MAP] && ce_in))
    else $error("map changed without a write");

  a_map_written: assert property (
    wr_ctl_w && pstrb_in[`LANE_MAP] |=>
    traffic_class_map_out == {$past(pwdata_in[7:1]), 1'b1})
    else $error("map write not stored");

  a_load_launch: assert property (
    load_write |=> table_load_req_out == UPSTREAM)
    else $error("load request not raised");

  a_zero_no_load: assert property (
    !table_load_req_out &&
    !(wr_ctl_w && pwdata_in[`LOAD_BIT] && uses_table_w) |=>
    !table_load_req_out)
    else $error("load raised without a one written");

  a_reserved_zero: assert property (
    rd_setup(`STS_ADDR) ##1 rd_done |->
    prdata_out[31:1] == 31'h0000_0000)
    else $error("reserved status bits not zero");

  // -----------------------------------------------------------------
  // Read paths, error response, load link and clock enable
  // -----------------------------------------------------------------

  // Setup of a read or write at one of the three mapped words
  sequence mapped_setup;
    psel_in && !penable_in && ce_in &&
    (paddr_in == `CAP_ADDR || paddr_in == `CTL_ADDR ||
     paddr_in == `STS_ADDR);
  endsequence

  // Setup at an address that no register answers
  sequence unmapped_setup;
    psel_in && !penable_in && ce_in && paddr_in != `CAP_ADDR &&
    paddr_in != `CTL_ADDR && paddr_in != `STS_ADDR;
  endsequence

  // Completion reported while a load is pending and the clock runs
  sequence load_finish;
    table_load_req_out && ce_in && table_load_done_in;
  endsequence

  // Any accepted write that misses the control word
  sequence other_write;
    access_w && pwrite_in && paddr_in != `CTL_ADDR;
  endsequence

  // Control readback must mirror the live map and select outputs
  a_ctl_readback: assert property (
    rd_setup(`CTL_ADDR) ##1 rd_done |->
    prdata_out[`TCMAP_MSB:`TCMAP_LSB-1] == traffic_class_map_out &&
    prdata_out[`SEL_MSB:`SEL_LSB] == arb_scheme_select_out)
    else $error("control readback differs from outputs");

  // Reserved control bits inside this block always read as zero
  a_ctl_reserved: assert property (
    rd_setup(`CTL_ADDR) ##1 rd_done |->
    prdata_out[15:8] == 8'h00 && prdata_out[23:20] == 4'h0 &&
    prdata_out[30:27] == 4'h0)
    else $error("reserved control bits not zero");

  // Capability bits between the scheme byte and the slot count
  a_cap_reserved: assert property (
    rd_setup(`CAP_ADDR) ##1 rd_done |->
    prdata_out[15:8] == 8'h00)
    else $error("reserved capability bits not zero");

  // Status readback shows the bit as it stood at setup
  a_status_readback: assert property (
    rd_setup(`STS_ADDR) ##1 rd_done |->
    prdata_out[`STATUS_BIT] == $past(table_status_out))
    else $error("status readback differs from status bit");

  // A mapped address never raises the error response
  a_mapped_no_err: assert property (
    mapped_setup ##1 rd_done |-> !pslverr_out)
    else $error("error on a mapped register");

  // An unmapped address answers with an error and zero data
  a_unmapped_err: assert property (
    unmapped_setup ##1 rd_done |-> pslverr_out && prdata_out == '0)
    else $error("unmapped access not flagged");

  // Only a control write may move the stored fields
  a_other_write_drop: assert property (
    other_write |=> $stable(traffic_class_map_out) &&
    $stable(arb_scheme_select_out))
    else $error("write to another word changed control fields");

  // The scheme select takes the written value when its lane is strobed
  a_sel_written: assert property (
    wr_ctl_w && pstrb_in[`LANE_LOAD] |=>
    arb_scheme_select_out == $past(pwdata_in[`SEL_MSB:`SEL_LSB]))
    else $error("scheme select write not stored");

  // Without a strobed control write the select stays put
  a_sel_stable: assert property (
    !(wr_ctl_w && pstrb_in[`LANE_LOAD]) |=> $stable(arb_scheme_select_out))
    else $error("scheme select changed without a write");

  // A pending load stands until the arbitration logic reports done
  a_load_holds: assert property (
    table_load_req_out && !(ce_in && table_load_done_in) |=>
    table_load_req_out)
    else $error("load request dropped before done");

  // A reported completion ends the request on the next edge
  a_load_ends: assert property (
    load_finish |=> !table_load_req_out)
    else $error("load request outlived done");

  // Completion without a racing entry write clears the status
  a_load_clears_status: assert property (
    table_load_req_out && ce_in && table_load_done_in &&
    !table_entry_write_in |=> !table_status_out)
    else $error("status still set after load");

  // Downstream ports never load and never mark the table
  a_down_quiet: assert property (
    UPSTREAM || (!table_load_req_out && !table_status_out))
    else $error("downstream port shows load activity");

  // A low clock enable freezes every stored field and the read data
  a_frozen_state: assert property (
    !ce_in |=> $stable(traffic_class_map_out) &&
    $stable(arb_scheme_select_out) && $stable(prdata_out) &&
    $stable(table_load_req_out) && $stable(table_status_out))
    else $error("state moved while the clock enable was low");
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the channel arbitration control registers
`timescale 1ns/10ps
`include "vc0_defines.svh"

module tb_top;
  // ---------------------------------------------------------------
  // Signals, two instances: index 0 upstream, index 1 downstream
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  // Shared clock enable, dropped once to prove the upstream port (index 0) freezes
  logic ce_in = 1'b1;
  logic [1:0] psel_in = 2'h0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [3:0] pstrb_in = 4'h0;
  logic entry_in = 1'b0;
  logic done_in = 1'b0;
  logic [31:0] rd [2];
  logic [1:0] rdy;
  logic [1:0] err;
  logic [1:0] req;
  logic [1:0] sts;
  logic [7:0] map [2];
  logic [2:0] sel [2];
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int n_tests = 0;

  // Clock at 25 MHz
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // Both ports share the bus lines; only psel tells them apart
  vc0_port_arb_control_regs #(.UPSTREAM(1'b1), .ADDR_W(12)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .psel_in(psel_in[0]), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(rd[0]), .pready_out(rdy[0]), .pslverr_out(err[0]),
    .table_entry_write_in(entry_in), .table_load_done_in(done_in),
    .table_load_req_out(req[0]), .table_status_out(sts[0]),
    .traffic_class_map_out(map[0]), .arb_scheme_select_out(sel[0]));
  vc0_port_arb_control_regs #(.UPSTREAM(1'b0), .ADDR_W(12)) DUT_DN (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .psel_in(psel_in[1]), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(rd[1]), .pready_out(rdy[1]), .pslverr_out(err[1]),
    .table_entry_write_in(entry_in), .table_load_done_in(done_in),
    .table_load_req_out(req[1]), .table_status_out(sts[1]),
    .traffic_class_map_out(map[1]), .arb_scheme_select_out(sel[1]));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input int u, input bit w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel_in[u] <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= w ? s : 4'h0;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Wait states are not assumed; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
    end while (rdy[u] !== 1'b1);
    q = rd[u];
    e = err[u];
    psel_in[u] <= 1'b0;
    penable_in <= 1'b0;
    // One idle edge keeps the next call off this time step
    @(posedge clk_in);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic pulse(input bit ent);
    if (ent) entry_in <= 1'b1;
    else done_in <= 1'b1;
    @(posedge clk_in);
    entry_in <= 1'b0;
    done_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic complete_run;
    $display("Tests done: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need under a hundred cycles
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Bit 31 of the control word is outside this block, so it is masked
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk(map[0], 8'hff, "map reset");
    chk({req[0], sts[0], sel[0]}, 5'h00, "load state reset");
    apb(0, 0, `CTL_ADDR, 0, 0);
    chk(q & 32'h7fff_ffff, 32'h0000_00ff, "ctl reset");
    apb(0, 0, `CAP_ADDR, 0, 0);
    chk(q, 32'h0200_0003, "cap upstream");
    chk(e, 1'b0, "cap no error");
    apb(1, 0, `CAP_ADDR, 0, 0);
    chk(q, 32'h0000_0001, "cap downstream");
    $display("Test reset values ended");

    // Writes to read-only and reserved places, load bit left at zero
    apb(0, 1, `CTL_ADDR, 32'h7f02_ff00, 4'hf);
    apb(0, 0, `CTL_ADDR, 0, 0);
    chk(q & 32'h7fff_ffff, 32'h0002_0001, "ctl masked write");
    chk({map[0], sel[0]}, {8'h01, 3'h1}, "ctl outputs");
    chk(req[0], 1'b0, "zero load bit");
    apb(0, 1, `CAP_ADDR, 32'hffff_ffff, 4'hf);
    apb(0, 0, `CAP_ADDR, 0, 0);
    chk(q, 32'h0200_0003, "cap write ignored");
    apb(0, 0, 12'h300, 0, 0);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0000_0000, "unmapped read");
    $display("Test access kinds ended");

    // Entry write, load request, completion
    pulse(1);
    chk(sts, 2'b01, "status after entry write");
    apb(0, 1, `CTL_ADDR, 32'h0003_00fe, 4'hf);
    @(posedge clk_in);
    chk(req[0], 1'b1, "load request raised");
    apb(0, 0, `CTL_ADDR, 0, 0);
    chk(q & 32'h7fff_ffff, 32'h0002_00ff, "load bit reads zero");
    chk(sts[0], 1'b1, "status held while loading");
    pulse(0);
    chk({req[0], sts[0]}, 2'b00, "load finished");
    apb(0, 0, `STS_ADDR, 0, 0);
    chk(q, 32'h0000_0000, "status polled clear");
    $display("Test table load ended");

    // Loads that must not start
    apb(0, 1, `CTL_ADDR, 32'h0001_00fe, 4'hf);
    @(posedge clk_in);
    chk(req[0], 1'b0, "fixed scheme load");
    apb(0, 1, `CTL_ADDR, 32'h0003_000e, 4'h1);
    @(posedge clk_in);
    chk({req[0], map[0], sel[0]}, {1'b0, 8'h0f, 3'h0}, "lane0 only");
    pulse(1);
    apb(1, 1, `CTL_ADDR, 32'h0001_0000, 4'hf);
    @(posedge clk_in);
    chk({req[1], sts[1]}, 2'b00, "downstream load");
    $display("Test refused loads ended");

    // A low clock enable must hold a pending load against done
    apb(0, 1, `CTL_ADDR, 32'h0003_00fe, 4'hf);
    ce_in <= 1'b0;
    pulse(0);
    chk({req[0], sts[0]}, 2'b11, "frozen through done");
    ce_in <= 1'b1;
    pulse(0);
    chk({req[0], sts[0]}, 2'b00, "load after enable");
    $display("Test clock enable ended");
    complete_run();
  end
endmodule
